// File: verilog/mbir_top.sv
`timescale 1ns/1ps
// How it works
// RULE1: two mailbox pages of eight registers
// RULE2: host writes page one, local writes two
// RULE3: word zero is status, seven data
// RULE4: only status writes ring the doorbell
// RULE5: host doorbell pushes fifo, local_irq_n when nonempty
// RULE6: local fifo read pops, local_irq_n drops empty
// RULE7: local doorbell queues system vector, inta asserts
// RULE8: host reads status, acks, reads vector
// RULE9: system vector carries written status copy
// RULE10: layer two vectors go to queues
// RULE11: fifo lines local_irq_n, optionally also inta
// RULE12: optional bridge of local irq to inta
// RULE13: port and system vectors masked after reset
// RULE14: source queue number steers the vector
// RULE15: channel vectors may go to queue seven
// RULE16: high priority mask bit per queue
// RULE17: queue write asserts inta
// RULE18: masked queue stores vector, no inta
// RULE19: device sets vector bit thirty one
// RULE20: mailbox registers hold until overwritten
module mbir_top (
   input  wire logic                        core_clk_i,
   input  wire logic                        sys_rst_i,
   input  wire logic                        ce_i,
   // host (pci) register port
   input  wire mbir_pkg::mbir_bus_t         hst_bus_i,
   output logic [mbir_pkg::DATA_W-1:0]      hst_rdata_o,
   // local processor register port
   input  wire mbir_pkg::mbir_bus_t         loc_bus_i,
   output logic [mbir_pkg::DATA_W-1:0]      loc_rdata_o,
   // layer two sources
   input  wire logic                        l2_valid_i,
   input  wire logic [mbir_pkg::DATA_W-1:0] l2_vector_i,
   input  wire logic [3:0]                  l2_queue_i,
   output logic                             l2_ready_o,
   // layer one sources into the local fifo
   input  wire logic                        l1_valid_i,
   input  wire logic [mbir_pkg::DATA_W-1:0] l1_vector_i,
   output logic                             l1_ready_o,
   // vector writes toward host memory queues
   output mbir_pkg::mbir_qwr_t              qwr_o,
   output logic                             qwr_valid_o,
   // interrupt pins
   input  wire logic                        ext_irq_n_i,
   output logic                             local_irq_n_o,
   output logic                             pci_inta_n_o
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [mbir_pkg::DATA_W-1:0]   h2l_r [mbir_pkg::PAGE_REGS];
   logic [mbir_pkg::DATA_W-1:0]   l2h_r [mbir_pkg::PAGE_REGS];
   logic [6:0]                    conf_r;
   logic [8:0]                    qmask_r;
   logic [7:0]                    hpmask_r;
   logic [8:0]                    gist_r;
   logic [8:0]                    gist_nxt;
   logic                          fifo_ovf_r;
   logic [2:0]                    ext_sync_r;
   logic                          ext_irq_r;
   logic [mbir_pkg::DATA_W-1:0]   hst_rdata_r;
   logic [mbir_pkg::DATA_W-1:0]   loc_rdata_r;
   mbir_pkg::mbir_qwr_t           qwr_r;
   logic                          qwr_valid_r;

   logic                          hst_page_hit;
   logic                          loc_page_hit;
   logic [2:0]                    hst_idx;
   logic [2:0]                    loc_idx;
   logic                          h2l_bell;
   logic                          l2h_bell;
   logic                          fifo_push;
   logic [mbir_pkg::DATA_W-1:0]   fifo_din;
   logic                          fifo_pop;
   logic [mbir_pkg::DATA_W-1:0]   fifo_head;
   logic                          fifo_empty;
   logic                          fifo_full;
   logic [mbir_pkg::FIFO_CNT_W-1:0] fifo_cnt;
   logic [1:0]                    l2_type;
   logic                          l2_allowed;
   logic                          l2_take;
   logic [3:0]                    l2_dest;
   logic [mbir_pkg::DATA_W-1:0]   sys_vec;
   logic                          q_wr;
   logic [3:0]                    q_num;
   logic [8:0]                    q_onehot;
   logic                          host_ack;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   // page hits use the upper address bits; word index picks the entry
   assign hst_page_hit = (hst_bus_i.addr[7:5] == mbir_pkg::HST_H2L_BASE[7:5]);
   assign loc_page_hit = (loc_bus_i.addr[7:5] == mbir_pkg::LOC_L2H_BASE[7:5]);
   assign hst_idx      = hst_bus_i.addr[4:2];
   assign loc_idx      = loc_bus_i.addr[4:2];

   // doorbell only on the status word, word zero of a page
   assign h2l_bell = hst_bus_i.wr & hst_page_hit & (hst_idx == 3'h0); // [RULE4]
   assign l2h_bell = loc_bus_i.wr & loc_page_hit & (loc_idx == 3'h0); // [RULE4]

   // ------------------------------------------------------------------
   // mailbox pages
   // ------------------------------------------------------------------
   // page one: only the host port writes it, local side reads it
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < mbir_pkg::PAGE_REGS; i++) begin
            h2l_r[i] <= '0; // [RULE1]
         end
      end else if (ce_i && hst_bus_i.wr && hst_page_hit) begin
         h2l_r[hst_idx] <= hst_bus_i.wdata; // [RULE2] [RULE3] [RULE20]
      end
   end

   // page two: only the local port writes it, host reads it
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < mbir_pkg::PAGE_REGS; i++) begin
            l2h_r[i] <= '0; // [RULE1]
         end
      end else if (ce_i && loc_bus_i.wr && loc_page_hit) begin
         l2h_r[loc_idx] <= loc_bus_i.wdata; // [RULE2] [RULE3] [RULE20]
      end
   end

   // ------------------------------------------------------------------
   // host configuration registers
   // ------------------------------------------------------------------
   // port/system enables reset low so no layer two port or system vector is queued after reset; mailbox system vectors are still queued
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         conf_r   <= mbir_pkg::CONF_RST; // [RULE13]
         qmask_r  <= mbir_pkg::QMASK_RST;
         hpmask_r <= mbir_pkg::HPMASK_RST;
      end else if (ce_i && hst_bus_i.wr) begin
         if (hst_bus_i.addr == mbir_pkg::HST_CONF_OFS) begin
            conf_r <= hst_bus_i.wdata[6:0];
         end
         if (hst_bus_i.addr == mbir_pkg::HST_QMASK_OFS) begin
            qmask_r <= hst_bus_i.wdata[8:0];
         end
         if (hst_bus_i.addr == mbir_pkg::HST_HPMASK_OFS) begin
            hpmask_r <= hst_bus_i.wdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // external local interrupt pin synchroniser
   // ------------------------------------------------------------------
   // three stages; the filtered level moves only when stages 2 and 3 agree
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ext_sync_r <= 3'h7;
         ext_irq_r  <= 1'b0;
      end else if (ce_i) begin
         ext_sync_r <= {ext_sync_r[1:0], ext_irq_n_i};
         if (ext_sync_r[1] == ext_sync_r[2]) begin
            ext_irq_r <= ~ext_sync_r[2];
         end
      end
   end

   // ------------------------------------------------------------------
   // internal interrupt fifo (mailbox and layer one)
   // ------------------------------------------------------------------
   // host doorbell has priority; layer one waits while a bell is pushed
   assign l1_ready_o = ~fifo_full & ~h2l_bell;
   assign fifo_push  = h2l_bell | (l1_valid_i & l1_ready_o); // [RULE5]
   assign fifo_din   = h2l_bell
                     ? {1'b1, mbir_pkg::TYPE_SYS, mbir_pkg::MB_STYPE,
                        6'h00, 1'b1, 4'h0, hst_bus_i.wdata[15:0]}
                     : l1_vector_i;
   // a local read of the fifo word removes the head entry
   assign fifo_pop   = loc_bus_i.rd
                     & (loc_bus_i.addr == mbir_pkg::LOC_FIFO_OFS); // [RULE6]

   mbir_irq_fifo u_fifo (
      .core_clk_i  (core_clk_i),
      .sys_rst_i   (sys_rst_i),
      .ce_i        (ce_i),
      .push_i      (fifo_push),
      .push_data_i (fifo_din),
      .pop_i       (fifo_pop),
      .head_o      (fifo_head),
      .empty_o     (fifo_empty),
      .full_o      (fifo_full),
      .count_o     (fifo_cnt)
   );

   // sticky flag: a doorbell found the fifo full and was lost
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fifo_ovf_r <= 1'b0;
      end else if (ce_i) begin
         if (h2l_bell && fifo_full) begin
            fifo_ovf_r <= 1'b1;
         end else if (loc_bus_i.wr
                      && loc_bus_i.addr == mbir_pkg::LOC_FSTAT_OFS) begin
            fifo_ovf_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // layer two vector routing
   // ------------------------------------------------------------------
   assign l2_type = l2_vector_i[mbir_pkg::VEC_TYPE_LSB +: 2];

   // port and system sources stay gated until software enables them
   always_comb begin
      unique case (l2_type)
         mbir_pkg::TYPE_PORT: l2_allowed = conf_r[mbir_pkg::CONF_PORT_EN];
         mbir_pkg::TYPE_SYS:  l2_allowed = conf_r[mbir_pkg::CONF_SYS_EN];
         default:             l2_allowed = 1'b1;
      endcase
   end

   // mailbox doorbell owns the queue writer in its cycle
   assign l2_ready_o = ~l2h_bell;
   assign l2_take    = l2_valid_i & l2_ready_o & l2_allowed; // [RULE13]

   // destination: source's choice, command queue, or high priority
   always_comb begin
      l2_dest = l2_queue_i; // [RULE14]
      if (l2_type == mbir_pkg::TYPE_CMD) begin
         l2_dest = mbir_pkg::CMD_QUEUE;
      end else if (l2_type == mbir_pkg::TYPE_CHAN && !l2_queue_i[3]
                   && hpmask_r[l2_queue_i[2:0]]) begin
         l2_dest = mbir_pkg::HP_QUEUE; // [RULE15] [RULE16]
      end
   end

   // mailbox system vector: queue field and a copy of the low 16 bits of the status word
   assign sys_vec = {1'b1, mbir_pkg::TYPE_SYS, mbir_pkg::MB_STYPE,
                     conf_r[mbir_pkg::CONF_SYSQ_LSB +: 3], 3'h0, 1'b1,
                     4'h0, loc_bus_i.wdata[15:0]}; // [RULE7] [RULE9]

   assign q_wr  = l2h_bell | l2_take; // [RULE10]
   assign q_num = l2h_bell
                ? {1'b0, conf_r[mbir_pkg::CONF_SYSQ_LSB +: 3]} // [RULE7]
                : l2_dest;

   // registered queue write toward the host memory writer
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         qwr_r       <= '0;
         qwr_valid_r <= 1'b0;
      end else if (ce_i) begin
         qwr_valid_r <= q_wr;
         if (q_wr) begin
            qwr_r.queue  <= q_num;
            qwr_r.vector <= l2h_bell ? sys_vec : l2_vector_i;
            qwr_r.vector[mbir_pkg::VEC_VALID_BIT] <= 1'b1; // [RULE19]
         end
      end
   end

   // ------------------------------------------------------------------
   // global interrupt status and acknowledge
   // ------------------------------------------------------------------
   assign host_ack = hst_bus_i.wr
                   & (hst_bus_i.addr == mbir_pkg::HST_GLOBAL_IRQ_ACKNOWLEDGE_OFS); // [RULE8]

   // one flag per queue, set by the queue write, cleared by writing one
   for (genvar q = 0; q < mbir_pkg::NUM_QUEUES; q++) begin : g_qflag
      assign q_onehot[q] = q_wr & (q_num == 4'(q));
      // set wins over a clear in the same cycle
      assign gist_nxt[q] = q_onehot[q]
                         | (gist_r[q] & ~(host_ack & hst_bus_i.wdata[q]));
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         gist_r <= '0;
      end else if (ce_i) begin
         gist_r <= gist_nxt; // [RULE17]
      end
   end

   // ------------------------------------------------------------------
   // interrupt pins
   // ------------------------------------------------------------------
   // local_irq_n follows fifo occupancy, or the synchronised external line
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         local_irq_n_o <= 1'b1;
      end else if (ce_i) begin
         local_irq_n_o <= fifo_empty & ~ext_irq_r; // [RULE5] [RULE6]
      end
   end

   // inta: unmasked queue flags, plus optional fifo and bridge paths
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pci_inta_n_o <= 1'b1;
      end else if (ce_i) begin
         pci_inta_n_o <= ~(|(gist_r & ~qmask_r) // [RULE17] [RULE18]
                         | (conf_r[mbir_pkg::CONF_FIFO2PCI]
                            & ~fifo_empty) // [RULE11]
                         | (conf_r[mbir_pkg::CONF_BRIDGE]
                            & ext_irq_r)); // [RULE12]
      end
   end

   // ------------------------------------------------------------------
   // read data, one cycle after the strobe
   // ------------------------------------------------------------------
   // unmapped addresses read zero
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hst_rdata_r <= '0;
      end else if (ce_i) begin
         hst_rdata_r <= '0;
         if (hst_bus_i.rd) begin
            if (hst_bus_i.addr[7:5] == mbir_pkg::HST_L2H_BASE[7:5]) begin
               hst_rdata_r <= l2h_r[hst_idx]; // [RULE2]
            end else if (hst_bus_i.addr == mbir_pkg::HST_GIST_OFS) begin
               hst_rdata_r <= {23'h0, gist_r}; // [RULE8]
            end else if (hst_bus_i.addr == mbir_pkg::HST_CONF_OFS) begin
               hst_rdata_r <= {25'h0, conf_r};
            end else if (hst_bus_i.addr == mbir_pkg::HST_QMASK_OFS) begin
               hst_rdata_r <= {23'h0, qmask_r};
            end else if (hst_bus_i.addr == mbir_pkg::HST_HPMASK_OFS) begin
               hst_rdata_r <= {24'h0, hpmask_r};
            end
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         loc_rdata_r <= '0;
      end else if (ce_i) begin
         loc_rdata_r <= '0;
         if (loc_bus_i.rd) begin
            if (loc_bus_i.addr[7:5] == mbir_pkg::LOC_H2L_BASE[7:5]) begin
               loc_rdata_r <= h2l_r[loc_idx]; // [RULE2] [RULE20]
            end else if (loc_page_hit) begin
               loc_rdata_r <= l2h_r[loc_idx];
            end else if (fifo_pop) begin
               // empty fifo reads zero, bit 31 clear marks no vector
               loc_rdata_r <= fifo_empty ? '0 : fifo_head; // [RULE6]
            end else if (loc_bus_i.addr == mbir_pkg::LOC_FSTAT_OFS) begin
               loc_rdata_r <= {26'h0, fifo_ovf_r, ~fifo_empty, fifo_cnt};
            end
         end
      end
   end

   assign hst_rdata_o = hst_rdata_r;
   assign loc_rdata_o = loc_rdata_r;
   assign qwr_o       = qwr_r;
   assign qwr_valid_o = qwr_valid_r;

endmodule

// File: verilog/mbir_pkg.sv
package mbir_pkg;

   // ------------------------------------------------------------------
   // widths and sizes
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned PAGE_REGS   = 8;
   localparam int unsigned NUM_QUEUES  = 9;
   localparam int unsigned FIFO_DEPTH  = 8;
   localparam int unsigned FIFO_CNT_W  = 4;

   // ------------------------------------------------------------------
   // host side register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] HST_H2L_BASE   = 8'h00;
   localparam logic [7:0] HST_L2H_BASE   = 8'h20;
   localparam logic [7:0] HST_GIST_OFS   = 8'h40;
   localparam logic [7:0] HST_GLOBAL_IRQ_ACKNOWLEDGE_OFS  = 8'h44;
   localparam logic [7:0] HST_CONF_OFS   = 8'h48;
   localparam logic [7:0] HST_QMASK_OFS  = 8'h4C;
   localparam logic [7:0] HST_HPMASK_OFS = 8'h50;

   // ------------------------------------------------------------------
   // local side register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] LOC_H2L_BASE   = 8'h00;
   localparam logic [7:0] LOC_L2H_BASE   = 8'h20;
   localparam logic [7:0] LOC_FIFO_OFS   = 8'h40;
   localparam logic [7:0] LOC_FSTAT_OFS  = 8'h44;

   // ------------------------------------------------------------------
   // config register fields and reset values
   // ------------------------------------------------------------------
   localparam int unsigned CONF_SYSQ_LSB    = 0;
   localparam int unsigned CONF_FIFO2PCI    = 3;
   localparam int unsigned CONF_BRIDGE      = 4;
   localparam int unsigned CONF_PORT_EN     = 5;
   localparam int unsigned CONF_SYS_EN      = 6;
   localparam logic [6:0]  CONF_RST         = 7'h00;
   localparam logic [8:0]  QMASK_RST        = 9'h000;
   localparam logic [7:0]  HPMASK_RST       = 8'h00;

   // ------------------------------------------------------------------
   // interrupt vector layout
   // ------------------------------------------------------------------
   localparam int unsigned VEC_VALID_BIT = 31;
   localparam int unsigned VEC_TYPE_LSB  = 29;
   localparam int unsigned VEC_STYPE_LSB = 27;
   localparam int unsigned VEC_QUEUE_LSB = 24;
   localparam int unsigned VEC_MB_BIT    = 20;
   localparam logic [1:0]  TYPE_CMD      = 2'h0;
   localparam logic [1:0]  TYPE_CHAN     = 2'h1;
   localparam logic [1:0]  TYPE_PORT     = 2'h2;
   localparam logic [1:0]  TYPE_SYS      = 2'h3;
   localparam logic [3:0]  HP_QUEUE      = 4'h7;
   localparam logic [3:0]  CMD_QUEUE     = 4'h8;
   localparam logic [1:0]  MB_STYPE      = 2'h0;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } mbir_bus_t;

   typedef struct packed {
      logic [DATA_W-1:0] vector;
      logic [3:0]        queue;
   } mbir_qwr_t;

endpackage

// File: verilog/mbir_irq_fifo.sv
`timescale 1ns/1ps
module mbir_irq_fifo (
   input  wire logic                            core_clk_i,
   input  wire logic                            sys_rst_i,
   input  wire logic                            ce_i,
   input  wire logic                            push_i,
   input  wire logic [mbir_pkg::DATA_W-1:0]     push_data_i,
   input  wire logic                            pop_i,
   output logic      [mbir_pkg::DATA_W-1:0]     head_o,
   output logic                                 empty_o,
   output logic                                 full_o,
   output logic      [mbir_pkg::FIFO_CNT_W-1:0] count_o
);

   // ------------------------------------------------------------------
   // storage and pointers
   // ------------------------------------------------------------------
   logic [mbir_pkg::DATA_W-1:0]     mem_r [mbir_pkg::FIFO_DEPTH];
   logic [mbir_pkg::FIFO_CNT_W-2:0] wptr_r;
   logic [mbir_pkg::FIFO_CNT_W-2:0] rptr_r;
   logic [mbir_pkg::FIFO_CNT_W-1:0] cnt_r;
   logic                            do_push;
   logic                            do_pop;

   // push into a full fifo is dropped, caller must watch full_o
   assign do_push = push_i & ~full_o;
   assign do_pop  = pop_i & ~empty_o;
   assign empty_o = (cnt_r == '0);
   assign full_o  = (cnt_r == mbir_pkg::FIFO_CNT_W'(mbir_pkg::FIFO_DEPTH));
   assign count_o = cnt_r;
   assign head_o  = mem_r[rptr_r];

   // entry memory, no reset needed on data
   always_ff @(posedge core_clk_i) begin
      if (ce_i && do_push) begin
         mem_r[wptr_r] <= push_data_i;
      end
   end

   // pointers and occupancy
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r  <= '0;
      end else if (ce_i) begin
         if (do_push) begin
            wptr_r <= wptr_r + 1'b1;
         end
         if (do_pop) begin
            rptr_r <= rptr_r + 1'b1;
         end
         if (do_push && !do_pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (do_pop && !do_push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

endmodule

// File: verification/mbir_top_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// port checker for the mailbox and interrupt router
// ------------------------------------------------------------------
module mbir_chk (
   input wire logic                core_clk_i,
   input wire logic                sys_rst_i,
   input wire logic                ce_i,
   input wire mbir_pkg::mbir_bus_t hst_bus_i,
   input wire mbir_pkg::mbir_bus_t loc_bus_i,
   input wire logic [31:0]         loc_rdata_o,
   input wire logic                l2_valid_i,
   input wire logic [31:0]         l2_vector_i,
   input wire logic [3:0]          l2_queue_i,
   input wire logic                l2_ready_o,
   input wire mbir_pkg::mbir_qwr_t qwr_o,
   input wire logic                qwr_valid_o,
   input wire logic                local_irq_n_o,
   input wire logic                pci_inta_n_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // doorbells and accepted layer two vectors
   logic hdb, ldb, l2t;
   assign hdb = ce_i & hst_bus_i.wr & (hst_bus_i.addr == 8'h00);
   assign ldb = ce_i & loc_bus_i.wr & (loc_bus_i.addr == 8'h20);
   assign l2t = ce_i & l2_valid_i & l2_ready_o;

   a_local_irq_n_ring: assert property (hdb |-> ##2 !local_irq_n_o)
      else $error("local irq not raised");
   a_sysvec_copy: assert property (ldb |=> qwr_valid_o && qwr_o.vector[20]
      && qwr_o.vector[15:0] == $past(loc_bus_i.wdata[15:0]))
      else $error("system vector wrong");
   a_vec_top: assert property (qwr_valid_o |-> qwr_o.vector[31])
      else $error("vector top bit clear");
   a_data_quiet: assert property (ce_i && loc_bus_i.wr && !l2_valid_i
      && loc_bus_i.addr inside {[8'h24:8'h3C]} |=> !qwr_valid_o)
      else $error("data write rang");
   a_cmd_route: assert property (l2t && l2_vector_i[30:29] == 2'h0
      |=> qwr_valid_o && qwr_o.queue == 4'h8) else $error("cmd queue");
   a_hp_route: assert property (l2t && l2_vector_i[30:29] == 2'h1
      && l2_queue_i == 4'h7 |=> qwr_o.queue == 4'h7) else $error("hp queue");
   a_rdata_idle: assert property (!loc_bus_i.rd |=> loc_rdata_o == '0)
      else $error("rdata not idle");
   a_reset_idle: assert property (disable iff (1'b0) sys_rst_i |->
      local_irq_n_o && pci_inta_n_o && !qwr_valid_o) else $error("reset");
   c_hdb: cover property (hdb);
   c_ldb: cover property (ldb);
   c_chan: cover property (l2t && l2_vector_i[30:29] == 2'h1);
endmodule

bind mbir_top mbir_chk i_chk (.core_clk_i, .sys_rst_i, .ce_i, .hst_bus_i,
   .loc_bus_i, .loc_rdata_o, .l2_valid_i, .l2_vector_i, .l2_queue_i,
   .l2_ready_o, .qwr_o, .qwr_valid_o, .local_irq_n_o, .pci_inta_n_o);

// File: verification/mbir_host_mem.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// host memory queues; only the newest entry is kept
// ------------------------------------------------------------------
module mbir_host_mem (
   input  wire logic                core_clk_i,
   input  wire mbir_pkg::mbir_qwr_t qwr_i,
   input  wire logic                qwr_valid_i,
   output mbir_pkg::mbir_qwr_t      last_o,
   output int                       n_wr_o
);
   initial n_wr_o = 0;
   // ring buffers not modelled, count catches lost or extra writes
   always @(posedge core_clk_i) begin
      if (qwr_valid_i) begin
         last_o <= qwr_i;
         n_wr_o <= n_wr_o + 1;
      end
   end
endmodule

// File: verification/test_mailbox_interrupt_routing.sv
`timescale 1ns/1ps
module test_mailbox_interrupt_routing;
   logic                core_clk_i = 1'b0;
   logic                sys_rst_i  = 1'b0;
   mbir_pkg::mbir_bus_t hst_bus_i = '0, loc_bus_i = '0;
   logic                l2_valid_i = 1'b0;
   logic [31:0]         l2_vector_i = '0, hst_rdata_o, loc_rdata_o, r;
   logic [3:0]          l2_queue_i = '0;
   mbir_pkg::mbir_qwr_t qwr_o, last;
   logic                qwr_valid_o, l2_ready_o, local_irq_n_o, pci_inta_n_o;
   int                  n_errors = 0, n_checks = 0, nwr;
   logic [31:0] tv [4] = '{32'h0000_0011, 32'h2000_0022, 32'h2000_0033,
                           32'h4000_0044};
   logic [3:0]  tq [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
   logic [3:0]  eq [4] = '{4'h8, 4'h7, 4'h3, 4'h4};

   always #12.5 core_clk_i = ~core_clk_i;
   mbir_top i_dut (.core_clk_i, .sys_rst_i, .ce_i(1'b1), .hst_bus_i,
      .hst_rdata_o, .loc_bus_i, .loc_rdata_o, .l2_valid_i, .l2_vector_i,
      .l2_queue_i, .l2_ready_o, .l1_valid_i(1'b0), .l1_vector_i(32'h0),
      .l1_ready_o(), .qwr_o, .qwr_valid_o, .ext_irq_n_i(1'b1),
      .local_irq_n_o, .pci_inta_n_o);
   mbir_host_mem i_host (.core_clk_i, .qwr_i(qwr_o), .qwr_valid_i(qwr_valid_o),
      .last_o(last), .n_wr_o(nwr));

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   // one strobe cycle, then idle; read data sampled in the cycle after
   task automatic acc(input bit loc, wr, input logic [7:0] a, logic [31:0] d);
      mbir_pkg::mbir_bus_t b;
      b = '{addr:a, wdata:d, wr:wr, rd:!wr};
      @(posedge core_clk_i);
      if (loc) loc_bus_i <= b; else hst_bus_i <= b;
      @(posedge core_clk_i);
      if (loc) loc_bus_i <= '0; else hst_bus_i <= '0;
      #1 r = loc ? loc_rdata_o : hst_rdata_o;
   endtask
   task automatic l2(input logic [31:0] v, input logic [3:0] q);
      @(posedge core_clk_i);
      l2_valid_i <= 1'b1;
      l2_vector_i <= v;
      l2_queue_i <= q;
      @(posedge core_clk_i);
      l2_valid_i <= 1'b0;
      cyc(1);
   endtask
   task automatic close_out;
      if (n_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // sequence; watchdog is generous, the run needs about 120 cycles
   // ------------------------------------------------------------------
   initial begin
      repeat (4000) @(posedge core_clk_i);
      n_errors++;
      close_out();
   end
   initial begin
      sys_rst_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      cyc(1);
      chk({pci_inta_n_o, local_irq_n_o, qwr_valid_o}, 3'b110);
      // host fills its page; data alone must not ring
      for (int i = 1; i < 8; i++) acc(0, 1, 8'(4*i), 32'hA000_0000 + i);
      cyc(2);
      chk(local_irq_n_o, 1);
      acc(0, 1, 8'h00, 32'h1234_5678);
      cyc(1);
      chk(local_irq_n_o, 0);
      for (int i = 0; i < 8; i++) begin
         acc(1, 0, 8'(4*i), 0);
         chk(r, i ? 32'hA000_0000 + i : 32'h1234_5678);
      end
      acc(1, 0, 8'h40, 0);
      chk(r, 32'hE010_5678);
      cyc(2);
      chk(local_irq_n_o, 1);
      // local side answers through host queue three
      acc(0, 1, 8'h48, 32'h3);
      for (int i = 1; i < 8; i++) acc(1, 1, 8'(32 + 4*i), 32'hB000_0000 + i);
      acc(1, 1, 8'h20, 32'h0000_9ABC);
      chk(qwr_valid_o, 1);
      cyc(1);
      chk(last.vector, 32'hE310_9ABC);
      chk(last.queue, 4'h3);
      chk(pci_inta_n_o, 0);
      acc(0, 0, 8'h40, 0);
      chk(r, 32'h8);
      acc(0, 1, 8'h44, 32'h8);
      cyc(2);
      chk(pci_inta_n_o, 1);
      for (int i = 1; i < 8; i++) begin
         acc(0, 0, 8'(32 + 4*i), 0);
         chk(r, 32'hB000_0000 + i);
      end
      acc(0, 0, 8'h60, 0);
      chk(r, 32'h0);
      // masked queue still stores, pin stays quiet
      acc(0, 1, 8'h4C, 32'h8);
      acc(1, 1, 8'h20, 32'h1);
      cyc(2);
      chk(pci_inta_n_o, 1);
      chk(nwr, 2);
      acc(0, 0, 8'h40, 0);
      chk(r, 32'h8);
      acc(0, 1, 8'h44, 32'h8);
      // port vectors dropped until enabled, then the routing table
      acc(0, 1, 8'h50, 32'h4);
      acc(0, 0, 8'h50, 0);
      chk(r, 32'h4);
      l2(32'h4000_0044, 4'h4);
      chk(nwr, 2);
      acc(0, 1, 8'h48, 32'h23);
      for (int i = 0; i < 4; i++) begin
         l2(tv[i], tq[i]);
         chk(last.queue, eq[i]);
         chk(last.vector[31], 1);
      end
      chk(nwr, 6);
      close_out();
   end
endmodule
